/* hdl/counter_pkg.sv */
// shared constants and carriers for the signed event counter bank
// assumes a single 50 MHz clock domain and no register bus
package counter_pkg;
   // instance count and data widths
   localparam int NUM_COUNTERS = 8;
   localparam int CNT_W = 32;
   localparam int TS_W = 64;
   // reset and arithmetic constants
   localparam logic [CNT_W-1:0] COUNT_ZERO = 32'h0000_0000;
   localparam logic [CNT_W-1:0] COUNT_STEP = 32'h0000_0001;
   localparam logic [TS_W-1:0] TIME_ZERO = 64'h0000_0000_0000_0000;
   // word layout in the retention store: even word count, odd word frozen value
   localparam logic WORD_IS_COUNT = 1'h0;
   localparam logic WORD_IS_FROZEN = 1'h1;

   // per counter logic operands, all levels
   typedef struct packed {
      logic enable;         // counter function on
      logic up;             // count-up operand
      logic down;           // count-down operand
      logic block;          // suspend counting, force flags off
      logic preset_select;  // preset_select_input
      logic reset_cmd;      // reset to preset or zero
      logic freeze_reset;   // capture then reset
      logic freeze_count;   // capture and keep counting
   } cnt_ctl_t;

   // per counter settings, both signed
   typedef struct packed {
      logic [CNT_W-1:0] preset;
      logic [CNT_W-1:0] setpoint;
   } cnt_cfg_t;

   // comparison outputs
   typedef struct packed {
      logic above_setpoint_flag;
      logic equal_setpoint_flag;
      logic below_setpoint_flag;
   } cmp_flags_t;

   localparam cmp_flags_t FLAGS_IDLE = 3'h0;
   localparam cnt_ctl_t CTL_IDLE = 8'h00;

   // retention store sequencer states
   typedef enum logic [1:0] {ST_IDLE, ST_SAVE, ST_LOAD} nv_state_t;
endpackage : counter_pkg

/* hdl/nv_word_store.sv */
// small word store standing in for the non-volatile retention memory
// assumes the caller sequences addresses; read data is registered
`timescale 1ns/1ps
module nv_word_store #(
   parameter int DW = 32,
   parameter int AW = 4
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // write port
   input wire logic wr_en_i,
   input wire logic [AW-1:0] wr_addr_i,
   input wire logic [DW-1:0] wr_data_i,
   // read port
   input wire logic rd_en_i,
   input wire logic [AW-1:0] rd_addr_i,
   output logic [DW-1:0] rd_data_o
);
   // storage array, no reset: contents must survive
   logic [DW-1:0] mem_r [2**AW];
   logic [DW-1:0] rd_data_r; // registered read word

   // write side
   always_ff @(posedge mclk_i) begin
      if (wr_en_i) begin
         mem_r[wr_addr_i] <= wr_data_i;
      end
   end

   // read side, one cycle latency
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         rd_data_r <= '0;
      end else if (rd_en_i) begin
         rd_data_r <= mem_r[rd_addr_i];
      end
   end

   assign rd_data_o = rd_data_r;
endmodule : nv_word_store

/* hdl/signed_event_counter.sv */
// bank of independent signed 32-bit event counters with setpoint compare,
// freeze capture with timestamp, and save/restore to a retention store
// assumes all operands are synchronous to mclk_i and held at least one cycle
`timescale 1ns/1ps
module signed_event_counter #(
   parameter int N = counter_pkg::NUM_COUNTERS
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // per counter operands and settings
   input wire counter_pkg::cnt_ctl_t [N-1:0] ctl_i,
   input wire counter_pkg::cnt_cfg_t [N-1:0] cfg_i,
   // date and time for freeze stamps
   input wire logic [counter_pkg::TS_W-1:0] time_now_i,
   // retention control
   input wire logic power_fail_i,
   input wire logic restore_i,
   // readout
   output logic [N-1:0][counter_pkg::CNT_W-1:0] count_o,
   output logic [N-1:0][counter_pkg::CNT_W-1:0] frozen_o,
   output logic [N-1:0][counter_pkg::TS_W-1:0] frozen_time_o,
   output counter_pkg::cmp_flags_t [N-1:0] flags_o,
   // retention status
   output logic nv_busy_o,
   output logic nv_saved_o
);
   localparam int AW = $clog2(2 * N);             // store address width
   localparam logic [AW-1:0] LAST_ADDR = AW'(2 * N - 1);

   // counter state
   logic [N-1:0][counter_pkg::CNT_W-1:0] count_r;
   logic [N-1:0][counter_pkg::CNT_W-1:0] frozen_r;
   logic [N-1:0][counter_pkg::TS_W-1:0] frozen_time_r;
   counter_pkg::cmp_flags_t [N-1:0] flags_r;
   counter_pkg::cnt_ctl_t [N-1:0] prev_r;        // operands one cycle ago

   // retention sequencer state
   counter_pkg::nv_state_t state_r;
   counter_pkg::nv_state_t state_nxt;
   logic [AW-1:0] addr_r;                         // walks every store word
   logic [AW-1:0] addr_nxt;
   logic pf_prev_r;                               // power_fail_i delayed
   logic rs_prev_r;                               // restore_i delayed
   logic ld_valid_r;                              // store read data valid
   logic [AW-1:0] ld_addr_r;                      // word that read data belongs to
   logic busy_r;
   logic saved_r;
   logic saved_nxt;

   // store connections
   wire [counter_pkg::CNT_W-1:0] ld_data;
   wire pf_rise = power_fail_i & ~pf_prev_r;
   wire rs_rise = restore_i & ~rs_prev_r;
   wire at_last = (addr_r == LAST_ADDR);
   wire wr_en = (state_r == counter_pkg::ST_SAVE);
   wire rd_en = (state_r == counter_pkg::ST_LOAD);
   wire [AW-2:0] wr_idx = addr_r[AW-1:1];
   // pick the word to save: even address count, odd address frozen value
   wire [counter_pkg::CNT_W-1:0] wr_data =
      (addr_r[0] == counter_pkg::WORD_IS_FROZEN) ? frozen_r[wr_idx] : count_r[wr_idx];

   // retention memory
   nv_word_store #(
      .DW(counter_pkg::CNT_W),
      .AW(AW)
   ) u_store (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .wr_en_i(wr_en),
      .wr_addr_i(addr_r),
      .wr_data_i(wr_data),
      .rd_en_i(rd_en),
      .rd_addr_i(addr_r),
      .rd_data_o(ld_data)
   );

   // sequencer next state: save has priority over restore
   always_comb begin
      state_nxt = state_r;
      addr_nxt = addr_r;
      saved_nxt = saved_r;
      case (state_r)
         counter_pkg::ST_IDLE: begin
            addr_nxt = '0;
            if (pf_rise) begin
               state_nxt = counter_pkg::ST_SAVE;
               saved_nxt = 1'b0;
            end else if (rs_rise) begin
               state_nxt = counter_pkg::ST_LOAD;
            end
         end
         counter_pkg::ST_SAVE: begin
            // one word per cycle into the store
            addr_nxt = AW'(addr_r + 1'b1);
            if (at_last) begin
               state_nxt = counter_pkg::ST_IDLE;
               saved_nxt = 1'b1;
            end
         end
         counter_pkg::ST_LOAD: begin
            addr_nxt = AW'(addr_r + 1'b1);
            if (at_last) begin
               state_nxt = counter_pkg::ST_IDLE;
            end
         end
         default: begin
            state_nxt = counter_pkg::ST_IDLE;
         end
      endcase
   end

   // sequencer registers
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         state_r <= counter_pkg::ST_IDLE;
         addr_r <= '0;
         pf_prev_r <= 1'b0;
         rs_prev_r <= 1'b0;
         ld_valid_r <= 1'b0;
         ld_addr_r <= '0;
         busy_r <= 1'b0;
         saved_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         addr_r <= addr_nxt;
         pf_prev_r <= power_fail_i;
         rs_prev_r <= restore_i;
         ld_valid_r <= rd_en;
         ld_addr_r <= addr_r;
         busy_r <= (state_nxt != counter_pkg::ST_IDLE);
         saved_r <= saved_nxt;
      end
   end

   // one identical counter per instance
   for (genvar i = 0; i < N; i++) begin : g_cnt
      localparam logic [AW-2:0] IDX = (AW-1)'(i);
      wire counter_pkg::cnt_ctl_t ctl = ctl_i[i];
      wire counter_pkg::cnt_cfg_t cfg = cfg_i[i];
      // rising edges of every operand
      wire counter_pkg::cnt_ctl_t rise = counter_pkg::cnt_ctl_t'(ctl & ~prev_r[i]);
      wire running = ctl.enable & ~ctl.block;
      // preset or zero, chosen by preset_select_input
      wire [counter_pkg::CNT_W-1:0] load_val =
         ctl.preset_select ? cfg.preset : counter_pkg::COUNT_ZERO;
      wire load_on_enable = rise.enable;
      wire load_on_cmd = ctl.enable & (rise.reset_cmd | rise.freeze_reset);
      wire load_on_preset = running & rise.preset_select;
      wire do_load = load_on_enable | load_on_cmd | load_on_preset;
      // count edges; both at once cancel out
      wire go_up = running & rise.up & ~rise.down;
      wire go_dn = running & rise.down & ~rise.up;
      wire do_cap = ctl.enable & (rise.freeze_reset | rise.freeze_count);
      // restore hits from the store read pipeline
      wire ld_hit = ld_valid_r & (ld_addr_r[AW-1:1] == IDX);
      wire ld_cnt = ld_hit & (ld_addr_r[0] == counter_pkg::WORD_IS_COUNT);
      wire ld_frz = ld_hit & (ld_addr_r[0] == counter_pkg::WORD_IS_FROZEN);
      // 32-bit sums wrap naturally at both limits
      wire [counter_pkg::CNT_W-1:0] inc = count_r[i] + counter_pkg::COUNT_STEP;
      wire [counter_pkg::CNT_W-1:0] dec = count_r[i] - counter_pkg::COUNT_STEP;
      wire [counter_pkg::CNT_W-1:0] count_nxt =
         ld_cnt ? ld_data :
         do_load ? load_val :
         go_up ? inc :
         go_dn ? dec : count_r[i];
      // signed compare of the present count
      wire gt = $signed(count_r[i]) > $signed(cfg.setpoint);
      wire lt = $signed(count_r[i]) < $signed(cfg.setpoint);
      wire eq = (count_r[i] == cfg.setpoint);
      wire counter_pkg::cmp_flags_t flags_nxt = running ?
         counter_pkg::cmp_flags_t'({gt, eq, lt}) : counter_pkg::FLAGS_IDLE;

      // running count and operand history
      always_ff @(posedge mclk_i or posedge rst_i) begin
         if (rst_i) begin
            count_r[i] <= counter_pkg::COUNT_ZERO;
            prev_r[i] <= counter_pkg::CTL_IDLE;
            flags_r[i] <= counter_pkg::FLAGS_IDLE;
         end else begin
            count_r[i] <= count_nxt;
            prev_r[i] <= ctl;
            flags_r[i] <= flags_nxt;
         end
      end

      // capture register with timestamp, taken before any reset
      always_ff @(posedge mclk_i or posedge rst_i) begin
         if (rst_i) begin
            frozen_r[i] <= counter_pkg::COUNT_ZERO;
            frozen_time_r[i] <= counter_pkg::TIME_ZERO;
         end else if (ld_frz) begin
            frozen_r[i] <= ld_data;
         end else if (do_cap) begin
            frozen_r[i] <= count_r[i];
            frozen_time_r[i] <= time_now_i;
         end
      end
   end

   // readout straight from the registers
   assign count_o = count_r;
   assign frozen_o = frozen_r;
   assign frozen_time_o = frozen_time_r;
   assign flags_o = flags_r;
   assign nv_busy_o = busy_r;
   assign nv_saved_o = saved_r;
endmodule : signed_event_counter

/* sim/signed_event_counter_monitor.sv */
// assertions on counter 0 of the event counter bank
// assumes a bind onto signed_event_counter, one clock domain
`timescale 1ns/1ps
module signed_event_counter_monitor #(
   parameter int N = 8
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // operands and settings
   input wire counter_pkg::cnt_ctl_t [N-1:0] ctl_i,
   input wire counter_pkg::cnt_cfg_t [N-1:0] cfg_i,
   input wire logic [counter_pkg::TS_W-1:0] time_now_i,
   input wire logic power_fail_i,
   // readout
   input wire logic [N-1:0][counter_pkg::CNT_W-1:0] count_o,
   input wire logic [N-1:0][counter_pkg::CNT_W-1:0] frozen_o,
   input wire logic [N-1:0][counter_pkg::TS_W-1:0] frozen_time_o,
   input wire counter_pkg::cmp_flags_t [N-1:0] flags_o,
   input wire logic nv_busy_o,
   input wire logic nv_saved_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   // counter 0 operands and a running state with no load pending
   wire counter_pkg::cnt_ctl_t c = ctl_i[0];
   wire calm = c.enable && !c.block && !c.reset_cmd && !c.freeze_reset && !c.preset_select
      && !nv_busy_o;
   wire signed [31:0] cv = count_o[0]; // signed view of the count
   wire signed [31:0] sv = cfg_i[0].setpoint; // signed view of the setpoint
   a_flags_off: assert property ((!c.enable || c.block)[*2] |-> flags_o[0] == 3'h0)
      else $error("flags active while idle");
   a_flag_compare: assert property (!$past(rst_i) && $past(c.enable && !c.block) |->
      flags_o[0] == {$past(cv) > $past(sv), $past(cv) == $past(sv), $past(cv) < $past(sv)})
      else $error("flags disagree with count");
   a_up_step: assert property ($rose(c.up) && !c.down && calm && $past(c.enable) |=>
      count_o[0] == $past(count_o[0]) + 32'h1) else $error("up step wrong");
   a_down_step: assert property ($rose(c.down) && !c.up && calm && $past(c.enable) |=>
      count_o[0] == $past(count_o[0]) - 32'h1) else $error("down step wrong");
   a_both_hold: assert property ($rose(c.up) && $rose(c.down) && calm && $past(c.enable)
      |=> $stable(count_o[0])) else $error("count moved on up and down");
   // preset select only loads while running, so a blocked counter is left out
   a_preset_rise: assert property (c.enable && !c.block && $past(c.enable)
      && $rose(c.preset_select) && !nv_busy_o |=> count_o[0] == $past(cfg_i[0].preset))
      else $error("preset not loaded");
   a_reset_zero: assert property (c.enable && $past(c.enable) && $rose(c.reset_cmd)
      && !c.preset_select && !nv_busy_o |=> count_o[0] == 32'h0) else $error("reset not zero");
   a_freeze_clear: assert property (c.enable && $rose(c.freeze_reset) && !c.preset_select
      && !nv_busy_o |=> frozen_o[0] == $past(count_o[0]) && count_o[0] == 32'h0)
      else $error("freeze and clear wrong");
   a_freeze_keep: assert property (c.enable && $rose(c.freeze_count) && !nv_busy_o |=>
      frozen_o[0] == $past(count_o[0]) && frozen_time_o[0] == $past(time_now_i))
      else $error("freeze capture wrong");
   a_save_done: assert property ($rose(power_fail_i) && !nv_busy_o |->
      ##[1:20] (nv_saved_o && !nv_busy_o)) else $error("save did not finish");
   // main scenarios reached
   c_wrap_down: cover property ($rose(c.down) && count_o[0] == 32'h8000_0000);
   c_freeze: cover property ($rose(c.freeze_reset) && c.enable);
   c_saved: cover property ($rose(nv_saved_o));
endmodule : signed_event_counter_monitor

/* sim/operand_pulser.sv */
// count-up operand source standing in for the protection logic
// assumes the caller shares the counter bank clock
`timescale 1ns/1ps
module operand_pulser (
   // clock
   input wire logic mclk_i,
   // operand
   output logic op_o
);
   initial op_o = 1'b0;
   // one high cycle then one low cycle per event
   task automatic pulses(input int n);
      repeat (n) begin
         @(negedge mclk_i) op_o = 1'b1;
         @(negedge mclk_i) op_o = 1'b0;
      end
   endtask : pulses
endmodule : operand_pulser

/* sim/test_signed_event_counter.sv */
// bench for the signed event counter bank, counter 0 worked in depth
// assumes the monitor and operand pulser compile first
`timescale 1ns/1ps
`define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin err_total++; \
   $display("unexpected %s exp %h got %h", nm, e, s); end end
module test_signed_event_counter;
   localparam int N = 8;
   // table row: load value, setpoint, up events, count and flags expected
   typedef struct {logic [31:0] pre, sp; int ups; logic [31:0] cnt; logic [2:0] fl;} row_t;
   row_t rows [4] = '{'{32'h7FFF_FFFE, 32'h8000_0000, 2, 32'h8000_0000, 3'h2},
      '{32'h0000_0005, 32'h0000_0007, 1, 32'h0000_0006, 3'h1},
      '{32'hFFFF_FFFF, 32'h0000_0001, 3, 32'h0000_0002, 3'h4},
      '{32'h8000_0000, 32'h0000_0000, 0, 32'h8000_0000, 3'h1}};
   logic mclk_i = 1'b0; // bench clock
   logic rst_i = 1'b1; // reset held at start
   counter_pkg::cnt_ctl_t [N-1:0] ct = '0; // bench operands
   counter_pkg::cnt_ctl_t [N-1:0] cw; // operands with partner merged
   counter_pkg::cnt_cfg_t [N-1:0] cf = '0; // settings
   logic [63:0] tnow = 64'h0123_4567_89AB_CDEF; // stamp source
   logic pf = 1'b0; // power fail
   logic rs = 1'b0; // restore
   logic up_w; // partner operand
   logic [N-1:0][31:0] cnt, frz;
   logic [N-1:0][63:0] ftm;
   counter_pkg::cmp_flags_t [N-1:0] fl;
   logic busy, saved;
   int err_total = 0;
   int checks_done = 0;
   always #10 mclk_i = ~mclk_i;
   // partner drives the count-up operand of counter 0
   always_comb begin
      cw = ct;
      cw[0].up = ct[0].up | up_w;
   end
   operand_pulser src (.mclk_i(mclk_i), .op_o(up_w));
   signed_event_counter #(.N(N)) uut (.mclk_i(mclk_i), .rst_i(rst_i), .ctl_i(cw), .cfg_i(cf),
      .time_now_i(tnow), .power_fail_i(pf), .restore_i(rs), .count_o(cnt), .frozen_o(frz),
      .frozen_time_o(ftm), .flags_o(fl), .nv_busy_o(busy), .nv_saved_o(saved));
   task automatic tk(input int n);
      repeat (n) @(negedge mclk_i);
   endtask : tk
   // raise operand bits of counter 0 for one cycle, then one low cycle
   task automatic hit(input logic [7:0] m);
      ct[0] = ct[0] | m;
      tk(1);
      ct[0] = ct[0] & ~m;
      tk(1);
   endtask : hit
   task automatic final_report;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : final_report
   // watchdog far beyond the expected run
   initial begin
      #200000;
      err_total++;
      final_report();
   end
   initial begin
      ct[7].enable = 1'b1;
      ct[7].preset_select = 1'b1;
      cf[7].preset = 32'h0000_0003;
      tk(6);
      rst_i = 1'b0;
      // table: load preset on enable, count up, compare
      foreach (rows[i]) begin
         ct[0] = counter_pkg::CTL_IDLE;
         cf[0] = {rows[i].pre, rows[i].sp};
         tk(1);
         ct[0].enable = 1'b1;
         ct[0].preset_select = 1'b1;
         tk(1);
         ct[0].preset_select = 1'b0;
         tk(1);
         src.pulses(rows[i].ups);
         tk(2);
         `CHK("count", rows[i].cnt, cnt[0])
         `CHK("flags", rows[i].fl, fl[0])
      end
      hit(8'h20);
      `CHK("wrap down", 32'h7FFF_FFFF, cnt[0])
      hit(8'h60);
      `CHK("up and down", 32'h7FFF_FFFF, cnt[0])
      hit(8'h01);
      `CHK("frozen", 32'h7FFF_FFFF, frz[0])
      `CHK("stamp", 64'h0123_4567_89AB_CDEF, ftm[0])
      `CHK("kept", 32'h7FFF_FFFF, cnt[0])
      cf[0].preset = 32'h0000_0010;
      ct[0].preset_select = 1'b1;
      tk(1);
      `CHK("select rise", 32'h0000_0010, cnt[0])
      src.pulses(1);
      hit(8'h04);
      `CHK("reset preset", 32'h0000_0010, cnt[0])
      ct[0].preset_select = 1'b0;
      tk(1);
      `CHK("select fall", 32'h0000_0010, cnt[0])
      // a new stamp value shows the capture happens at the freeze edge
      tnow = 64'hFEDC_BA98_7654_3210;
      hit(8'h02);
      `CHK("frozen clr", 32'h0000_0010, frz[0])
      `CHK("stamp clr", 64'hFEDC_BA98_7654_3210, ftm[0])
      `CHK("cleared", 32'h0000_0000, cnt[0])
      ct[0].block = 1'b1;
      src.pulses(2);
      tk(1);
      `CHK("blocked", 32'h0000_0000, cnt[0])
      `CHK("flags off", 3'h0, fl[0])
      ct[0].block = 1'b0;
      src.pulses(3);
      // preset select raised while disabled, then enable loads the preset
      ct[0].enable = 1'b0;
      ct[0].preset_select = 1'b1;
      tk(1);
      ct[0].enable = 1'b1;
      tk(1);
      `CHK("enable preset", 32'h0000_0010, cnt[0])
      ct[0].enable = 1'b0;
      ct[0].preset_select = 1'b0;
      tk(1);
      ct[0].enable = 1'b1;
      tk(1);
      `CHK("enable zero", 32'h0000_0000, cnt[0])
      src.pulses(2);
      pf = 1'b1;
      for (int i = 0; i < 40 && !saved; i++) tk(1);
      `CHK("saved", 1'b1, saved)
      hit(8'h04);
      rs = 1'b1;
      tk(2);
      for (int i = 0; i < 40 && busy; i++) tk(1);
      `CHK("idle again", 1'b0, busy)
      tk(4);
      `CHK("restored", 32'h0000_0002, cnt[0])
      `CHK("restored frz", 32'h0000_0010, frz[0])
      `CHK("other unit", 32'h0000_0003, cnt[7])
      `CHK("idle unit", 32'h0000_0000, cnt[1])
      rst_i = 1'b1;
      tk(2);
      rst_i = 1'b0;
      tk(3);
      `CHK("after reset", 32'h0000_0000, cnt[0])
      `CHK("equal flag", 3'h2, fl[0])
      final_report();
   end
endmodule : test_signed_event_counter
bind signed_event_counter signed_event_counter_monitor #(.N(N)) mon (.mclk_i, .rst_i, .ctl_i,
   .cfg_i, .time_now_i, .power_fail_i, .count_o, .frozen_o, .frozen_time_o, .flags_o,
   .nv_busy_o, .nv_saved_o);
